// *** pkg/status_flags_pkg.sv ***
/*
 * Shared constants for the channel status flag block: register byte
 * offsets, control field positions, command codes and reset values.
 * Assumes a 32-bit APB register bus and one 200 MHz clock domain.
 */
package status_flags_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_STAT   = 8'h08;
    localparam logic [7:0] OFS_RXDATA = 8'h0C;
    localparam logic [7:0] OFS_TXHOLD = 8'h10;
    localparam logic [7:0] OFS_ISR    = 8'h14;
    localparam logic [7:0] OFS_IMR    = 8'h18;

    // Control register fields
    localparam int CTRL_TX_EN    = 0;
    localparam int CTRL_PMODE_LO = 1;
    localparam int CTRL_PTYPE    = 3;
    localparam int CTRL_FIFO16   = 4;
    localparam int CTRL_W        = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h04;

    // Parity mode field values
    localparam logic [1:0] PMODE_WITH  = 2'h0;
    localparam logic [1:0] PMODE_FORCE = 2'h1;
    localparam logic [1:0] PMODE_NONE  = 2'h2;
    localparam logic [1:0] PMODE_MDROP = 2'h3;

    // Command codes, written to the low nibble of the command register
    localparam logic [3:0] CMD_RX_RESET  = 4'h2;
    localparam logic [3:0] CMD_TX_RESET  = 4'h3;
    localparam logic [3:0] CMD_ERR_RESET = 4'h4;

    // Status register bit positions
    localparam int ST_BRK   = 7;
    localparam int ST_FRM   = 6;
    localparam int ST_PAR   = 5;
    localparam int ST_OVR   = 4;
    localparam int ST_TRANSMIT_IDLE_FLAG = 3;
    localparam int ST_TRANSMIT_READY_FLAG = 2;
    localparam int ST_FULL  = 1;
    localparam int ST_RXRDY = 0;

    // Interrupt status bit positions
    localparam int IRQ_OVR   = 0;
    localparam int IRQ_RXRDY = 1;
    localparam int IRQ_TRANSMIT_IDLE_FLAG = 2;
    localparam int IRQ_PAR   = 3;
    localparam int IRQ_W     = 4;

    // Receive FIFO depths
    localparam int FIFO_DEPTH_SHALLOW = 8;
    localparam int FIFO_DEPTH_DEEP    = 16;

endpackage

// *** rtl/status_flags.sv ***
/*
 * Per-character error flags, overrun handling and transmitter empty and
 * ready flags for one asynchronous serial channel, with an APB slave.
 * Assumes the receiver and transmitter shifters run on clk_sys and give
 * one-cycle pulses; the transmitter takes a held character only while
 * tx_enable is high.
 */
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps

// Operation
// - With or forced parity selected, a character with bad parity gets its parity flag set and kept in its FIFO entry.
// - In multi-drop mode the parity flag position holds the received address/data marker.
// - Overrun is set when a character arrives while the FIFO is full and one already waits in the shift register.
// - On overrun the waiting character and its break, parity and framing status are discarded.
// - Overrun is cleared only by the reset-error-status command, never by reading characters.
// - The empty flag is set on underrun, when the transmitter is idle and ready at once.
// - Empty and ready are set when the transmitter is enabled, first or again after reset or disable.
// - Empty is set after the last stop bit when nothing waits in the holding store.
// - The FIFO is full at eight entries in shallow mode and sixteen in deep mode.
// - Error flags travel with each FIFO entry and the reset-error-status command clears them.
// - Empty is cleared on a holding store load, a pending disable taking effect, a reset or a disable in underrun.
module status_flags
#(
    parameter int DEPTH = status_flags_pkg::FIFO_DEPTH_DEEP
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Receiver shifter
    input  wire logic        rx_char_valid,
    input  wire logic [7:0]  rx_char_data,
    input  wire logic        rx_char_parity,
    input  wire logic        rx_char_break,
    input  wire logic        rx_char_framing,
    // Transmitter shifter
    output logic [7:0]       tx_hold_data,
    output logic             tx_hold_valid,
    output logic             tx_enable,
    input  wire logic        tx_shift_take,
    input  wire logic        tx_stop_done,
    // Interrupt
    output logic             irq
);
    import status_flags_pkg::*;

    localparam int PW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////
    // Bus decode

    logic                bus_setup;
    logic                bus_done;
    logic                wr_done;
    logic                rd_done;
    logic [CTRL_W-1:0]   ctrl_q;
    logic [IRQ_W-1:0]    isr_q;
    logic [IRQ_W-1:0]    imr_q;
    logic                cmd_wr;
    logic [3:0]          cmd_code;
    logic                err_clr;
    logic                rx_clr;
    logic                tx_clr;
    logic                hold_wr;
    logic                rx_pop_req;

    // One wait state: data captured in the first access cycle
    assign bus_setup  = psel & penable & ~pready;
    assign bus_done   = psel & penable & pready;
    assign wr_done    = bus_done & pwrite;
    assign rd_done    = bus_done & ~pwrite;
    assign cmd_wr     = wr_done && paddr == OFS_CMD;
    assign cmd_code   = pwdata[3:0];
    assign err_clr    = cmd_wr && cmd_code == CMD_ERR_RESET;
    assign rx_clr     = cmd_wr && cmd_code == CMD_RX_RESET;
    assign tx_clr     = cmd_wr && cmd_code == CMD_TX_RESET;
    assign hold_wr    = wr_done && paddr == OFS_TXHOLD;
    assign rx_pop_req = rd_done && paddr == OFS_RXDATA;

    ////////////////////////////////////////////////////////////////////
    // Receive path

    logic [7:0]      fifo_data_q [DEPTH];
    logic [2:0]      fifo_err_q  [DEPTH];
    logic [PW-1:0]   wr_ptr_q;
    logic [PW-1:0]   rd_ptr_q;
    logic [PW:0]     count_q;
    logic [PW:0]     limit;
    logic            full;
    logic            pop;
    logic            space;
    logic            pend_q;
    logic [7:0]      pend_data_q;
    logic [2:0]      pend_err_q;
    logic            ovr_q;
    logic            new_perr;
    logic [2:0]      new_err;
    logic            push;
    logic [7:0]      push_data;
    logic [2:0]      push_err;
    logic            ovr_evt;

    // Full threshold follows the depth mode
    assign limit = ctrl_q[CTRL_FIFO16] ? (PW+1)'(FIFO_DEPTH_DEEP)
                                       : (PW+1)'(FIFO_DEPTH_SHALLOW);
    assign full  = count_q >= limit;
    assign pop   = rx_pop_req && count_q != '0;
    assign space = !full || pop;

    // Parity result, or the address/data marker in multi-drop mode
    always_comb
    begin
        case (ctrl_q[CTRL_PMODE_LO +: 2])
            // Even type: total ones must be even; odd type flips the sense
            PMODE_WITH:  new_perr = (^rx_char_data) ^ rx_char_parity
                                    ^ ctrl_q[CTRL_PTYPE];
            PMODE_FORCE: new_perr = rx_char_parity ^ ctrl_q[CTRL_PTYPE];
            PMODE_MDROP: new_perr = rx_char_parity;
            default:     new_perr = 1'b0;
        endcase
    end

    assign new_err = {rx_char_break, rx_char_framing, new_perr};

    // A waiting character enters the FIFO before a new one, unless an overrun overwrites it
    assign push      = space && (pend_q || rx_char_valid);
    assign push_data = pend_q ? pend_data_q : rx_char_data;
    assign push_err  = pend_q ? pend_err_q : new_err;
    assign ovr_evt   = rx_char_valid && pend_q && !space;

    // Shift-register holding slot
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_q      <= 1'b0;
            pend_data_q <= 8'h00;
            pend_err_q  <= 3'h0;
        end
        else if (rx_clr)
        begin
            pend_q <= 1'b0;
        end
        else if (rx_char_valid && (pend_q || !space))
        begin
            // Old waiting character and its status are overwritten
            pend_q      <= 1'b1;
            pend_data_q <= rx_char_data;
            pend_err_q  <= new_err;
        end
        else if (push && pend_q)
        begin
            pend_q <= 1'b0;
        end
    end

    // FIFO pointers and fill level
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else if (rx_clr)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
            count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Entry storage; error bits stay with their character
    generate
        for (genvar i = 0; i < DEPTH; i++)
        begin : g_entry
            always_ff @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    fifo_data_q[i] <= 8'h00;
                    fifo_err_q[i]  <= 3'h0;
                end
                else if (push && wr_ptr_q == PW'(i))
                begin
                    fifo_data_q[i] <= push_data;
                    fifo_err_q[i]  <= push_err;
                end
                else if (err_clr)
                begin
                    fifo_err_q[i] <= 3'h0;
                end
            end
        end
    endgenerate

    // Overrun: sticky until the error reset command; reads leave it
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            ovr_q <= 1'b0;
        else if (ovr_evt)
            ovr_q <= 1'b1;
        else if (err_clr)
            ovr_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Transmit path

    logic        tx_on_q;
    logic        busy_q;
    logic        rdy_q;
    logic        emt_q;
    logic        en_req;
    logic        dis_req;
    logic        enable_evt;
    logic        dis_take;
    logic        underrun;

    assign en_req     = ctrl_q[CTRL_TX_EN];
    assign enable_evt = en_req && !tx_on_q && !tx_clr;
    // Disable waits for the character in flight; immediate if idle
    assign dis_req    = !en_req && tx_on_q;
    assign dis_take   = dis_req && !busy_q && !tx_hold_valid;
    assign underrun   = tx_on_q && !busy_q && rdy_q && !tx_hold_valid;

    // Effective enable and shifter activity
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_on_q <= 1'b0;
            busy_q  <= 1'b0;
        end
        else
        begin
            if (tx_clr || dis_take)
                tx_on_q <= 1'b0;
            else if (enable_evt)
                tx_on_q <= 1'b1;
            if (tx_clr)
                busy_q <= 1'b0;
            else if (tx_shift_take)
                busy_q <= 1'b1;
            else if (tx_stop_done)
                busy_q <= 1'b0;
        end
    end

    // Holding store; a load while not ready is dropped
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_hold_valid <= 1'b0;
            tx_hold_data  <= 8'h00;
        end
        else if (tx_clr)
        begin
            tx_hold_valid <= 1'b0;
        end
        else if (hold_wr && rdy_q)
        begin
            tx_hold_valid <= 1'b1;
            tx_hold_data  <= pwdata[7:0];
        end
        else if (tx_shift_take)
        begin
            tx_hold_valid <= 1'b0;
        end
    end

    // Ready flag: store free, transmitter on and no disable requested
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rdy_q <= 1'b0;
        else if (tx_clr || dis_req)
            rdy_q <= 1'b0;
        else if (enable_evt)
            rdy_q <= 1'b1;
        else if (hold_wr && rdy_q)
            rdy_q <= 1'b0;
        else if (tx_shift_take)
            rdy_q <= 1'b1;
    end

    // Empty flag; clears take priority over sets in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            emt_q <= 1'b0;
        else if (tx_clr || dis_take)
            emt_q <= 1'b0;
        else if (dis_req && emt_q)
            emt_q <= 1'b0;
        else if (hold_wr && rdy_q)
            emt_q <= 1'b0;
        else if (enable_evt)
            emt_q <= 1'b1;
        else if (tx_stop_done && !tx_hold_valid && tx_on_q)
            emt_q <= 1'b1;
        else if (underrun)
            emt_q <= 1'b1;
    end

    assign tx_enable = tx_on_q;

    ////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    logic [IRQ_W-1:0] irq_set;

    assign irq_set[IRQ_OVR]   = ovr_evt;
    assign irq_set[IRQ_RXRDY] = push;
    assign irq_set[IRQ_TRANSMIT_IDLE_FLAG] = !emt_q && (enable_evt || underrun
                                || (tx_stop_done && !tx_hold_valid && tx_on_q));
    assign irq_set[IRQ_PAR]   = push && push_err[0];

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            isr_q <= '0;
        else if (wr_done && paddr == OFS_ISR)
            isr_q <= (isr_q & ~pwdata[IRQ_W-1:0]) | irq_set;
        else
            isr_q <= isr_q | irq_set;
    end

    // Level output, one cycle behind the status
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= |(isr_q & imr_q);
    end

    ////////////////////////////////////////////////////////////////////
    // Writable registers

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= CTRL_RESET;
            imr_q  <= '0;
        end
        else if (wr_done)
        begin
            if (paddr == OFS_CTRL)
                ctrl_q <= pwdata[CTRL_W-1:0];
            else if (paddr == OFS_IMR)
                imr_q <= pwdata[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data and handshake

    logic [7:0]  status;
    logic [2:0]  top_err;
    logic        mapped;

    assign top_err = count_q != '0 ? fifo_err_q[rd_ptr_q] : 3'h0;
    assign status  = {top_err, ovr_q, emt_q, rdy_q, full, count_q != '0};

    always_comb
    begin
        if (paddr == OFS_CTRL || paddr == OFS_CMD || paddr == OFS_STAT
            || paddr == OFS_RXDATA || paddr == OFS_TXHOLD
            || paddr == OFS_ISR || paddr == OFS_IMR)
            mapped = 1'b1;
        else
            mapped = 1'b0;
    end

    // Status read is side-effect free; only RXDATA pops
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            prdata <= 32'h0000_0000;
        else if (bus_setup && !pwrite)
        begin
            if (paddr == OFS_CTRL)
                prdata <= {27'h0, ctrl_q};
            else if (paddr == OFS_STAT)
                prdata <= {24'h0, status};
            else if (paddr == OFS_RXDATA)
                prdata <= {24'h0, fifo_data_q[rd_ptr_q]};
            else if (paddr == OFS_ISR)
                prdata <= {28'h0, isr_q};
            else if (paddr == OFS_IMR)
                prdata <= {28'h0, imr_q};
            else
                prdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= bus_setup;
            pslverr <= bus_setup && !mapped;
        end
    end

endmodule

// *** dv/status_flags_checker.sv ***
/*
 * Checker for the status flag block: bus handshake and transmit store flags.
 * Bound to every status_flags instance; sees only its ports.
 */
`timescale 1ns/1ps
module status_flags_checker
    import status_flags_pkg::*;
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Transmit store
    input wire logic [7:0]  tx_hold_data,
    input wire logic        tx_hold_valid,
    input wire logic        tx_enable,
    input wire logic        tx_shift_take
);
    ////////////////////////////////////////////////////////////////////////////
    // Completed write, the edge at which it takes effect
    wire acc_wr = psel && penable && pready && pwrite;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    a_one_wait_state: assert property ($rose(penable) && psel |=> pready)
        else $error("pready not in second access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // Load only counts when the store was free, else it is dropped
    a_store_load: assert property (acc_wr && paddr == OFS_TXHOLD && tx_enable && !tx_hold_valid
        |=> tx_hold_valid && tx_hold_data == $past(pwdata[7:0]))
        else $error("holding store not loaded");
    a_take_frees: assert property (tx_shift_take |=> !tx_hold_valid)
        else $error("store still full after take");
    a_store_keeps: assert property (tx_hold_valid && !tx_shift_take && !acc_wr
        |=> tx_hold_valid)
        else $error("store lost without take");
    a_enable_follows: assert property (acc_wr && paddr == OFS_CTRL && pwdata[CTRL_TX_EN]
        |-> ##[1:2] tx_enable)
        else $error("transmitter not enabled");
    a_txreset_clears: assert property (acc_wr && paddr == OFS_CMD
        && pwdata[3:0] == CMD_TX_RESET |=> !tx_hold_valid)
        else $error("tx reset left store full");

    c_load: cover property (acc_wr && paddr == OFS_TXHOLD);
    c_take: cover property (tx_shift_take);
    c_slverr: cover property (pslverr);
    c_enable: cover property ($rose(tx_enable));
endmodule

bind status_flags status_flags_checker u_checker (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .tx_hold_data(tx_hold_data), .tx_hold_valid(tx_hold_valid),
    .tx_enable(tx_enable), .tx_shift_take(tx_shift_take)
);

// *** dv/serial_partner.sv ***
/*
 * Model of the receive and transmit shifters beside the status flag block.
 * Same clock as the block; the bench calls send and drives hold_off.
 */
`timescale 1ns/1ps
module serial_partner
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Stall of the transmit shifter
    input  wire logic       hold_off,
    // Receive side
    output logic            rx_char_valid,
    output logic [7:0]      rx_char_data,
    output logic            rx_char_parity,
    output logic            rx_char_break,
    output logic            rx_char_framing,
    // Transmit side
    input  wire logic       tx_hold_valid,
    input  wire logic       tx_enable,
    output logic            tx_shift_take,
    output logic            tx_stop_done
);
    logic [2:0] shift_cnt_q;

    initial
    begin
        rx_char_valid = 1'b0;
        {rx_char_data, rx_char_parity, rx_char_break, rx_char_framing} = 11'h0;
    end

    // One character; lines show the inverse afterwards, not a stale copy
    task automatic send(input logic [7:0] d, input logic p, input logic b, input logic f);
        @(posedge clk_sys);
        rx_char_valid <= 1'b1;
        {rx_char_data, rx_char_parity, rx_char_break, rx_char_framing} <= {d, p, b, f};
        @(posedge clk_sys);
        rx_char_valid <= 1'b0;
        {rx_char_data, rx_char_parity, rx_char_break, rx_char_framing} <= ~{d, p, b, f};
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Single shift register: takes only when a char is held and enabled
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_cnt_q   <= 3'h0;
            tx_shift_take <= 1'b0;
            tx_stop_done  <= 1'b0;
        end
        else
        begin
            tx_shift_take <= 1'b0;
            tx_stop_done  <= 1'b0;
            if (shift_cnt_q != 3'h0)
            begin
                shift_cnt_q  <= shift_cnt_q - 3'h1;
                tx_stop_done <= (shift_cnt_q == 3'h1);
            end
            else if (tx_hold_valid && tx_enable && !hold_off && !tx_shift_take)
            begin
                tx_shift_take <= 1'b1;
                shift_cnt_q   <= 3'h4;
            end
        end
    end
endmodule

// *** dv/status_flags_bench.sv ***
/*
 * Self-checking bench for the status flag block: APB tasks and directed
 * sequences. Assumes serial_partner models the shifters.
 */
`timescale 1ns/1ps
module status_flags_bench;
    import status_flags_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        hold_off = 1'b0;
    logic        err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic [31:0] prdata;
    logic [7:0]  rx_char_data;
    logic [7:0]  tx_hold_data;
    logic        pready, pslverr, rx_char_valid, rx_char_parity, rx_char_break;
    logic        rx_char_framing, tx_hold_valid, tx_enable, tx_shift_take;
    logic        tx_stop_done, irq;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          dep;
    logic        exp_par;

    always #2.5 clk_sys = ~clk_sys;

    status_flags dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
        .rx_char_parity(rx_char_parity), .rx_char_break(rx_char_break),
        .rx_char_framing(rx_char_framing), .tx_hold_data(tx_hold_data),
        .tx_hold_valid(tx_hold_valid), .tx_enable(tx_enable),
        .tx_shift_take(tx_shift_take), .tx_stop_done(tx_stop_done), .irq(irq)
    );

    serial_partner u_partner (
        .clk_sys(clk_sys), .rst_b(rst_b), .hold_off(hold_off),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
        .rx_char_parity(rx_char_parity), .rx_char_break(rx_char_break),
        .rx_char_framing(rx_char_framing), .tx_hold_valid(tx_hold_valid),
        .tx_enable(tx_enable), .tx_shift_take(tx_shift_take), .tx_stop_done(tx_stop_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // One transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc(OFS_CTRL, 32'h04, "ctrl");
        rdc(OFS_STAT, 32'h00, "stat");
        rdc(8'h1C, 32'h00, "unmapped");
        chk("slverr", 32'h1, {31'h0, err});
        // First enable, then the masked and unmasked interrupt
        wr(OFS_CTRL, 32'h01);
        rdc(OFS_STAT, 32'h0C, "stat");
        rdc(OFS_ISR, 32'h04, "isr");
        chk("irq", 32'h0, {31'h0, irq});
        wr(OFS_IMR, 32'h04);
        rdc(OFS_ISR, 32'h04, "isr");
        chk("irq", 32'h1, {31'h0, irq});
        wr(OFS_ISR, 32'h04);
        rdc(OFS_ISR, 32'h00, "isr");
        chk("irq", 32'h0, {31'h0, irq});
        // Stalled shifter keeps the char in the store
        hold_off <= 1'b1;
        wr(OFS_TXHOLD, 32'h5A);
        rdc(OFS_STAT, 32'h00, "stat");
        chk("hold", 32'h5A, {24'h0, tx_hold_data});
        wr(OFS_CMD, {28'h0, CMD_TX_RESET});
        rdc(OFS_STAT, 32'h0C, "stat");
        chk("hold valid", 32'h0, {31'h0, tx_hold_valid});
        wr(OFS_TXHOLD, 32'hA5);
        hold_off <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rdc(OFS_STAT, 32'h0C, "stat");
        wr(OFS_CTRL, 32'h00);
        rdc(OFS_STAT, 32'h00, "stat");
        chk("tx enable", 32'h0, {31'h0, tx_enable});
        wr(OFS_CTRL, 32'h01);
        rdc(OFS_STAT, 32'h0C, "stat");
        chk("tx enable", 32'h1, {31'h0, tx_enable});
        // Every parity mode and type, both values of the received bit
        for (int m = 0; m < 4; m++)
            for (int p = 0; p < 4; p++)
            begin
                wr(OFS_CTRL, 32'h1 | (m << CTRL_PMODE_LO) | (p[1] << CTRL_PTYPE));
                u_partner.send(8'h07, p[0], 1'b0, 1'b0);
                // Data holds three ones: even type wants a one, odd type a zero
                exp_par = (m == PMODE_NONE) ? 1'b0 : (m == PMODE_MDROP) ? p[0]
                        : (m == PMODE_WITH) ? !p[0] ^ p[1] : p[0] ^ p[1];
                rdc(OFS_STAT, 32'h0D | (exp_par << ST_PAR), "stat");
                rdc(OFS_RXDATA, 32'h07, "rx data");
            end
        // Fill, wait, overrun at both depths; no parity
        for (int k = 0; k < 2; k++)
        begin
            dep = k ? FIFO_DEPTH_DEEP : FIFO_DEPTH_SHALLOW;
            wr(OFS_CTRL, 32'h05 | (k << CTRL_FIFO16));
            for (int i = 0; i < dep + 2; i++)
            begin
                u_partner.send(i[7:0], 1'b0, i == dep + 1, 1'b0);
                if (i == dep - 2 || i == dep)
                    rdc(OFS_STAT, (i == dep) ? 32'h0F : 32'h0D, "stat");
            end
            rdc(OFS_STAT, 32'h1F, "stat");
            for (int i = 0; i < dep; i++)
                rdc(OFS_RXDATA, i, "rx data");
            rdc(OFS_STAT, 32'h9D, "stat");
            rdc(OFS_RXDATA, dep + 1, "rx data");
            rdc(OFS_STAT, 32'h1C, "stat");
            u_partner.send(8'h55, 1'b0, 1'b0, 1'b1);
            rdc(OFS_STAT, 32'h5D, "stat");
            wr(OFS_CMD, {28'h0, CMD_ERR_RESET});
            rdc(OFS_STAT, 32'h0D, "stat");
            rdc(OFS_RXDATA, 32'h55, "rx data");
        end
        tally_and_finish();
    end
endmodule
